// ===== hw/adcc_pkg.sv
// package: field layout, constants and carriers for the adc control register
package adcc_pkg;
  // ==========================================================
  // frame and register layout
  localparam int CFG_W        = 12;
  localparam int FRAME_EDGES  = 16;
  localparam int CFG_EDGES    = 12;
  localparam int MUX_EDGE     = 14;
  localparam int LIST_W       = 16;
  localparam int RES_W        = 12;
  localparam int BIT_WRITE    = 11;
  localparam int BIT_SEQ      = 10;
  localparam int BIT_ADDR_HI  = 8;
  localparam int BIT_ADDR_LO  = 6;
  localparam int BIT_PM1      = 5;
  localparam int BIT_PM0      = 4;
  localparam int BIT_LISTSEL  = 3;
  localparam int BIT_RANGE    = 1;
  localparam int BIT_CODING   = 0;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'hFF1;
  localparam logic [LIST_W-1:0] LIST_RESET = 16'h0000;
  // ==========================================================
  // timing
  localparam int CLK_NS       = 40;
  localparam int WAKE_NS      = 1000;
  localparam int WAKE_CYC     = (WAKE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ADCC_PM_INVALID  = 2'b00,
    ADCC_PM_AUTO     = 2'b01,
    ADCC_PM_SHUTDOWN = 2'b10,
    ADCC_PM_NORMAL   = 2'b11
  } adcc_pm_t;

  typedef struct packed {
    logic [2:0] channel;
    logic       powered;
    logic       awake;
    logic       range_ref;
    logic       straight_bin;
    logic       seq_active;
    logic       pm_invalid;
  } adcc_ctrl_t;
endpackage

// ===== hw/adcc_ctrl_reg.sv
// module: serial control register of the eight-channel converter
`timescale 1ns/1ps
// Function
// - twelve-bit write-only configuration register, no read-back.
// - bits captured from serial input on falling serial clock edges.
// - word arrives while result shifts out; configures next conversion.
// - only first twelve falling edges load the register.
// - first bit is register bit 11, then downward to bit 0.
// - bit 11 high loads the other bits, low keeps the register.
// - bits 10 and 3 choose sequencer mode and list access.
// - address bits applied at conversion end, pick next or final channel.
// - address decodes as binary, value n selects input n.
// - output frame sends channel address before twelve result bits.
// - multiplexer switches to next channel on fourteenth falling edge.
// - power field: 11 normal, 10 shutdown, 01 auto, 00 invalid.
// - normal mode stays powered regardless of logic inputs.
// - full shutdown holds until a write changes the power field.
// - configuration kept while shut down.
// - auto mode shuts down at end of each conversion after update.
// - range bit 0 gives twice-reference span, 1 gives reference span.
// - coding bit 0 twos complement, 1 straight binary.
// - sequencer off: each conversion uses prior write's address.
// - list select alone: next frame's sixteen bits load channel list.
// - sequencer bit alone: write keeps running sequence going.
// - both set: consecutive channels from zero to address field.
module adcc_ctrl_reg (
  input  wire logic                      clock,
  input  wire logic                      rst_n,
  input  wire logic                      clk_en,
  input  wire logic                      sclk_pin,
  input  wire logic                      cs_n_pin,
  input  wire logic                      din_pin,
  input  wire logic [adcc_pkg::RES_W-1:0] result,
  output logic                           dout,
  output adcc_pkg::adcc_ctrl_t           ctrl
);
  import adcc_pkg::*;

  // ==========================================================
  // pin synchronisers
  // edges land 2-3 clocks late, so each sclk phase needs 3 clocks
  logic [1:0] sclk_s_r, cs_s_r, din_s_r;
  logic       sclk_d_r;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_s_r <= 2'h3;
      cs_s_r   <= 2'h3;
      din_s_r  <= 2'h0;
      sclk_d_r <= 1'b1;
    end else if (clk_en) begin
      sclk_s_r <= {sclk_s_r[0], sclk_pin};
      cs_s_r   <= {cs_s_r[0], cs_n_pin};
      din_s_r  <= {din_s_r[0], din_pin};
      sclk_d_r <= sclk_s_r[1];
    end
  end
  wire sclk_q = sclk_s_r[1];
  wire cs_q   = cs_s_r[1];
  wire din_q  = din_s_r[1];
  wire fall   = clk_en && !cs_q && sclk_d_r && !sclk_q;
  wire rise   = clk_en && !cs_q && !sclk_d_r && sclk_q;

  // ==========================================================
  // frame state
  logic [4:0]        edge_r, edge_nxt;
  logic [CFG_W-1:0]  shift_r, shift_nxt;
  logic [LIST_W-1:0] lshift_r, lshift_nxt;
  logic [CFG_W-1:0]  cfg_r, cfg_nxt;
  logic [LIST_W-1:0] list_r, list_nxt;
  logic              list_pend_r, list_pend_nxt;
  logic [2:0]        chan_r, chan_nxt;
  logic [2:0]        conv_ch_r, conv_ch_nxt;
  logic [3:0]        seq_idx_r, seq_idx_nxt;
  logic              seq_run_r, seq_run_nxt;
  logic              asleep_r, asleep_nxt;
  logic [$clog2(WAKE_CYC+1)-1:0] wake_r, wake_nxt;
  logic [15:0]       out_r, out_nxt;
  logic              cs_d_r;

  wire frame_start = clk_en && cs_d_r && !cs_q;
  wire frame_end   = clk_en && !cs_d_r && cs_q;
  wire [CFG_W-1:0] cfg_word = {shift_r[CFG_W-2:0], din_q};

  // next channel in list from idx, wrapping
  // full 16-slot scan: a wide mux, but it settles in one clock
  function automatic logic [3:0] list_next(input logic [LIST_W-1:0] l,
                                           input logic [3:0] from);
    logic [3:0] r;
    logic       hit;
    r   = from;
    hit = 1'b0;
    for (int k = 1; k <= LIST_W; k++) begin
      if (!hit && l[LIST_W-1-4'((from + 4'(k)) % LIST_W)]) begin
        r   = 4'((from + 4'(k)) % LIST_W);
        hit = 1'b1;
      end
    end
    return r;
  endfunction

  always_comb begin
    edge_nxt      = edge_r;
    shift_nxt     = shift_r;
    lshift_nxt    = lshift_r;
    cfg_nxt       = cfg_r;
    list_nxt      = list_r;
    list_pend_nxt = list_pend_r;
    chan_nxt      = chan_r;
    conv_ch_nxt   = conv_ch_r;
    seq_idx_nxt   = seq_idx_r;
    seq_run_nxt   = seq_run_r;
    asleep_nxt    = asleep_r;
    wake_nxt      = wake_r;
    out_nxt       = out_r;
    if (frame_start) begin
      edge_nxt = '0;
      // address of this result leads the data
      out_nxt  = {1'b0, conv_ch_r, result};
    end
    if (rise && edge_r != 5'd0)
      out_nxt = {out_r[14:0], 1'b0};
    if (fall && edge_r < 5'(FRAME_EDGES)) begin
      edge_nxt   = edge_r + 5'd1;
      lshift_nxt = {lshift_r[LIST_W-2:0], din_q};
      if (edge_r < 5'(CFG_EDGES))
        shift_nxt = cfg_word;      // msb first
      if (edge_r == 5'(CFG_EDGES-1) && !list_pend_r && cfg_word[BIT_WRITE])
        cfg_nxt = cfg_word;
      if (edge_r == 5'(MUX_EDGE-1))
        chan_nxt = conv_ch_r;
    end
    if (frame_end) begin
      if (list_pend_r) begin
        // list frame: its bits feed the list, the word path stays shut
        list_nxt      = lshift_r;
        list_pend_nxt = 1'b0;
        seq_run_nxt   = 1'b1;
        seq_idx_nxt   = list_next(lshift_r, 4'hF);
        conv_ch_nxt   = 3'(list_next(lshift_r, 4'hF));
      end else if (cfg_r[BIT_SEQ] && cfg_r[BIT_LISTSEL]) begin
        // consecutive 0..addr
        seq_run_nxt = 1'b1;
        conv_ch_nxt = (seq_run_r && conv_ch_r < cfg_r[BIT_ADDR_HI:BIT_ADDR_LO])
                      ? conv_ch_r + 3'd1 : 3'd0;
      end else if (cfg_r[BIT_SEQ] && seq_run_r) begin
        // running sequence untouched
        seq_idx_nxt = list_next(list_r, seq_idx_r);
        conv_ch_nxt = 3'(list_next(list_r, seq_idx_r));
      end else begin
        seq_run_nxt   = 1'b0;
        conv_ch_nxt   = cfg_r[BIT_ADDR_HI:BIT_ADDR_LO];
        list_pend_nxt = !cfg_r[BIT_SEQ] && cfg_r[BIT_LISTSEL];
      end
      // auto mode sleeps here and wakes at the next cs fall
      asleep_nxt = cfg_r[BIT_PM1:BIT_PM0] != ADCC_PM_NORMAL;
    end
    if (clk_en) begin
      if (cfg_r[BIT_PM1:BIT_PM0] == ADCC_PM_NORMAL)
        asleep_nxt = 1'b0;
      else if (cfg_r[BIT_PM1:BIT_PM0] == ADCC_PM_AUTO && frame_start)
        asleep_nxt = 1'b0;
      // awake lags powered by the wake time; earlier results are suspect
      if (asleep_nxt)
        wake_nxt = '0;
      else if (wake_r < ($bits(wake_r))'(WAKE_CYC))
        wake_nxt = wake_r + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      edge_r      <= '0;
      shift_r     <= '0;
      lshift_r    <= '0;
      cfg_r       <= CFG_RESET;
      list_r      <= LIST_RESET;
      list_pend_r <= 1'b0;
      chan_r      <= '0;
      conv_ch_r   <= '0;
      seq_idx_r   <= '0;
      seq_run_r   <= 1'b0;
      asleep_r    <= 1'b0;
      wake_r      <= '0;
      out_r       <= '0;
      cs_d_r      <= 1'b1;
    end else begin
      edge_r      <= edge_nxt;
      shift_r     <= shift_nxt;
      lshift_r    <= lshift_nxt;
      cfg_r       <= cfg_nxt;   // kept through shutdown
      list_r      <= list_nxt;
      list_pend_r <= list_pend_nxt;
      chan_r      <= chan_nxt;
      conv_ch_r   <= conv_ch_nxt;
      seq_idx_r   <= seq_idx_nxt;
      seq_run_r   <= seq_run_nxt;
      asleep_r    <= asleep_nxt;
      wake_r      <= wake_nxt;
      out_r       <= out_nxt;
      if (clk_en)
        cs_d_r <= cs_q;
    end
  end

  // ==========================================================
  // outputs; word applies to the following conversion
  // nothing reads cfg_r back out; dout only carries the channel address and results
  assign dout              = out_r[15];
  assign ctrl.channel      = chan_r;
  assign ctrl.powered      = !asleep_r;
  assign ctrl.awake        = !asleep_r && wake_r == ($bits(wake_r))'(WAKE_CYC);
  assign ctrl.range_ref    = cfg_r[BIT_RANGE];
  assign ctrl.straight_bin = cfg_r[BIT_CODING];
  assign ctrl.seq_active   = seq_run_r;
  assign ctrl.pm_invalid   = cfg_r[BIT_PM1:BIT_PM0] == ADCC_PM_INVALID;

  // ==========================================================
  // checks
  a_write_gated: assert property (@(posedge clock) disable iff (!rst_n)
    (cfg_r != $past(cfg_r)) |-> $past(cfg_word[BIT_WRITE]))
    else $error("config changed without write bit");
  a_late_bits: assert property (@(posedge clock) disable iff (!rst_n)
    (fall && edge_r >= 5'(CFG_EDGES)) |=> $stable(cfg_r))
    else $error("config changed after twelfth edge");
  a_mux_edge: assert property (@(posedge clock) disable iff (!rst_n)
    (chan_r != $past(chan_r)) |-> $past(fall && edge_r == 5'(MUX_EDGE-1)))
    else $error("mux moved off fourteenth edge");
  a_normal_pwr: assert property (@(posedge clock) disable iff (!rst_n)
    (clk_en && cfg_r[5:4] == ADCC_PM_NORMAL) |=> ctrl.powered)
    else $error("normal mode not powered");
  a_shutdown_hold: assert property (@(posedge clock) disable iff (!rst_n)
    (asleep_r && cfg_r[5:4] == ADCC_PM_SHUTDOWN && $stable(cfg_r))
      |=> asleep_r)
    else $error("shutdown left without write");
  a_range_out: assert property (@(posedge clock) disable iff (!rst_n)
    ctrl.range_ref == cfg_r[BIT_RANGE])
    else $error("range output mismatch");
  a_addr_first: assert property (@(posedge clock) disable iff (!rst_n)
    frame_start |=> out_r[14:12] == $past(conv_ch_r))
    else $error("address not ahead of result");
  a_edge_bound: assert property (@(posedge clock) disable iff (!rst_n)
    edge_r <= 5'(FRAME_EDGES))
    else $error("edge count overflow");
  c_write: cover property (@(posedge clock) disable iff (!rst_n)
    fall && edge_r == 5'(CFG_EDGES-1) && cfg_word[BIT_WRITE]);
  c_list: cover property (@(posedge clock) list_pend_r ##1 !list_pend_r);
  c_sleep: cover property (@(posedge clock) !asleep_r ##1 asleep_r);
  c_seq: cover property (@(posedge clock) seq_run_r && cfg_r[BIT_LISTSEL]);
  c_auto: cover property (@(posedge clock) disable iff (!rst_n)
    frame_end && cfg_r[BIT_PM1:BIT_PM0] == ADCC_PM_AUTO);

  // ==========================================================
  // checks: loading, sequencer, power, clock enable freeze and coding output
  a_cfg_load: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fall && edge_r == 5'(CFG_EDGES-1) && !list_pend_r &&
     cfg_word[BIT_WRITE]) |=> cfg_r == $past(cfg_word))
    else $error("written word not loaded");
  a_list_load: assert property (
    @(posedge clock) disable iff (!rst_n)
    (frame_end && list_pend_r) |=> list_r == $past(lshift_r) && !list_pend_r)
    else $error("channel list not loaded");
  a_list_no_cfg: assert property (
    @(posedge clock) disable iff (!rst_n)
    (fall && list_pend_r) |=> $stable(cfg_r))
    else $error("list frame touched config");
  a_plain_chan: assert property (
    @(posedge clock) disable iff (!rst_n)
    (frame_end && !list_pend_r && !cfg_r[BIT_SEQ]) |=>
      (!seq_run_r && conv_ch_r == $past(cfg_r[BIT_ADDR_HI:BIT_ADDR_LO])))
    else $error("plain mode channel not from address");
  a_consec_seq: assert property (
    @(posedge clock) disable iff (!rst_n)
    (frame_end && !list_pend_r && cfg_r[BIT_SEQ] && cfg_r[BIT_LISTSEL]) |=>
      (seq_run_r && conv_ch_r <= $past(cfg_r[BIT_ADDR_HI:BIT_ADDR_LO])))
    else $error("consecutive sequence past final channel");
  a_seq_keep: assert property (
    @(posedge clock) disable iff (!rst_n)
    (frame_end && !list_pend_r && cfg_r[BIT_SEQ] && !cfg_r[BIT_LISTSEL] &&
     seq_run_r) |=> seq_run_r)
    else $error("running sequence interrupted");
  a_auto_sleep: assert property (
    @(posedge clock) disable iff (!rst_n)
    (frame_end && cfg_r[BIT_PM1:BIT_PM0] == ADCC_PM_AUTO) |=> !ctrl.powered)
    else $error("auto mode stayed powered");
  a_sleep_cfg: assert property (
    @(posedge clock) disable iff (!rst_n)
    (asleep_r && !fall) |=> $stable(cfg_r))
    else $error("config lost in shutdown");
  a_wake_late: assert property (
    @(posedge clock) disable iff (!rst_n)
    $rose(ctrl.powered) |-> !ctrl.awake)
    else $error("awake without wake time");
  a_freeze_all: assert property (
    @(posedge clock) disable iff (!rst_n)
    !clk_en |=> ($stable(cfg_r) && $stable(edge_r) && $stable(out_r) &&
                 $stable(list_r)))
    else $error("state moved with clock enable low");
  a_coding_out: assert property (
    @(posedge clock) disable iff (!rst_n)
    ctrl.straight_bin == cfg_r[BIT_CODING])
    else $error("coding output mismatch");
endmodule

// ===== tb/adcc_host.sv
// host serial master model for the converter's serial port
`timescale 1ns/1ps
module adcc_host (
  input  wire logic clock,
  input  wire logic dout,
  output logic      sclk_pin,
  output logic      cs_n_pin,
  output logic      din_pin
);
  initial begin
    sclk_pin = 1'b1;
    cs_n_pin = 1'b1;
    din_pin  = 1'b0;
  end
  // ==========================================================
  // one frame, sclk half period of 4 system clocks
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge clock);
    cs_n_pin = 1'b0;
    din_pin  = tx[15];
    repeat (8) @(negedge clock);
    for (int i = 15; i >= 0; i--) begin
      sclk_pin = 1'b0;
      repeat (4) @(negedge clock);
      rx[i] = dout;
      sclk_pin = 1'b1;
      // data moves on the rise, so it stands across the fall
      if (i > 0) din_pin = tx[i-1];
      repeat (4) @(negedge clock);
    end
    cs_n_pin = 1'b1;
    // deselected line must not show the last bit
    din_pin = ~din_pin;
    repeat (8) @(negedge clock);
  endtask
endmodule

// ===== tb/adcc_ctrl_reg_tb.sv
// self-checking bench for the serial control register
`timescale 1ns/1ps
module adcc_ctrl_reg_tb;
  import adcc_pkg::*;
  logic             clock;
  logic             rst_n;
  logic             sclk_pin;
  logic             cs_n_pin;
  logic             din_pin;
  logic             dout;
  logic [RES_W-1:0] result;
  adcc_ctrl_t       ctrl;
  logic [15:0]      rx;
  int               bad_count;
  int               checked;
  logic [1:0]       pms [4] = '{2'b10, 2'b11, 2'b01, 2'b11};
  logic             pwr [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  adcc_ctrl_reg dut (
    .clock(clock), .rst_n(rst_n), .clk_en(1'b1), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .din_pin(din_pin), .result(result),
    .dout(dout), .ctrl(ctrl));
  adcc_host host (
    .clock(clock), .dout(dout), .sclk_pin(sclk_pin),
    .cs_n_pin(cs_n_pin), .din_pin(din_pin));

  // ==========================================================
  // compares and helpers
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] ec(logic [2:0] ch, logic p, r, c);
    adcc_ctrl_t e;
    e = '{ch, p, p, r, c, 1'b0, 1'b0};
    return 16'(e);
  endfunction
  // trailing nibble set so ignored edges carry ones
  task automatic frame(logic [11:0] cfg);
    host.xfer({cfg, 4'hF}, rx);
    repeat (30) @(negedge clock);
  endtask
  task automatic stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    stop_test;
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0;
    result = 12'hA5C;
    bad_count = 0;
    checked = 0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    repeat (2) @(negedge clock);
    check("awake", 16'h0, 16'(ctrl.awake));
    repeat (30) @(negedge clock);
    check("ctrl", ec(0, 1, 0, 1), 16'(ctrl));
    $display("test reset finished");
    frame(12'h970);
    check("dout", {4'h0, 12'hA5C}, rx);
    // mux follows the new address one frame later
    check("ctrl", ec(0, 1, 0, 0), 16'(ctrl));
    frame(12'h7FF);
    check("dout", {4'h5, 12'hA5C}, rx);
    check("ctrl", ec(5, 1, 0, 0), 16'(ctrl));
    $display("test write bit finished");
    for (int n = 0; n < 8; n++) begin
      // odd channels also set the two ignored bits
      frame(12'h833 | 12'(n << 6) | (n[0] ? 12'h204 : 12'h000));
      check("dout", {1'b0, 3'(n == 0 ? 5 : n - 1), 12'hA5C}, rx);
      check("ctrl", ec(3'(n == 0 ? 5 : n - 1), 1, 1, 1), 16'(ctrl));
    end
    $display("test channels finished");
    for (int k = 0; k < 4; k++) begin
      frame({6'h27, pms[k], 4'h3});
      check("ctrl", ec(7, pwr[k], 1, 1), 16'(ctrl));
      if (k == 0) begin
        frame(12'h000);
        check("ctrl", ec(7, 0, 1, 1), 16'(ctrl));
      end
    end
    $display("test power finished");
    frame(12'hCBB);
    check("seq", 16'h1, 16'(ctrl.seq_active));
    frame(12'hEB3);
    check("seq", 16'h1, 16'(ctrl.seq_active));
    frame(12'h8B3);
    check("ctrl", ec(0, 1, 1, 1), 16'(ctrl));
    frame(12'h8BB);
    check("ctrl", ec(2, 1, 1, 1), 16'(ctrl));
    // taken as config this word would mark the power field invalid
    host.xfer(16'h8000, rx);
    repeat (30) @(negedge clock);
    check("invalid", 16'h0, 16'(ctrl.pm_invalid));
    $display("test sequencer finished");
    stop_test;
  end
endmodule
